// File: rtl/io_expander_defines.vh
// Constants for the 16-bit I/O expander control logic
`ifndef IO_EXPANDER_DEFINES_VH
`define IO_EXPANDER_DEFINES_VH
`define ADDR_FIXED_BITS 5'h1d
`define CMD_INPUT_0 3'h0
`define CMD_INPUT_1 3'h1
`define CMD_OUTPUT_0 3'h2
`define CMD_OUTPUT_1 3'h3
`define CMD_POLARITY_0 3'h4
`define CMD_POLARITY_1 3'h5
`define CMD_CONFIG_0 3'h6
`define CMD_CONFIG_1 3'h7
`define RST_OUTPUT 8'hff
`define RST_POLARITY 8'h00
`define RST_CONFIG 8'hff
`define RST_INPUT 8'h00
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_FIRST 4'h0
`define REG_COUNT 4'h8
`endif

// File: rtl/reg_bank.v
// Small register bank holding the expander's eight byte registers
module reg_bank #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Registered read port
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data,
  // Full contents for the port logic
  output wire [WIDTH*DEPTH-1:0] all_data
);
`include "io_expander_defines.vh"
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : flat
      assign all_data[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate
  function [WIDTH-1:0] reset_value;
    input integer idx;
    begin
      if (idx == `CMD_OUTPUT_0 || idx == `CMD_OUTPUT_1)
        reset_value = `RST_OUTPUT;
      else if (idx == `CMD_POLARITY_0 || idx == `CMD_POLARITY_1)
        reset_value = `RST_POLARITY;
      else if (idx == `CMD_CONFIG_0 || idx == `CMD_CONFIG_1)
        reset_value = `RST_CONFIG;
      else
        reset_value = `RST_INPUT;
    end
  endfunction
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= reset_value(i);
      rd_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: rtl/io_expander_ctrl.v
// Two-wire target, reset, interrupt and address select of the expander
// Notes on behaviour
// - Power-up loads register defaults and returns bus logic to idle.
// - Reset pin gives the same defaulting as power-up.
// - Interrupt asserts while any sampled pin configured as input differs from stored input.
// - Interrupt is open drain: pulls low asserted, released otherwise.
// - Interrupt tells the master inputs changed, avoiding polling.
// - Device is a bus target only, never starts a transfer.
// - Output pins hold latched values until rewritten or reset.
// - Two address-select pins form part of the target address.
module io_expander_ctrl (
  // Clock and synchronous reset (power-on reset drives this too)
  input wire clk,
  input wire resetn,
  // Active-low reset pin from the master
  input wire ext_reset_n,
  // Address select straps
  input wire addr_select_0,
  input wire addr_select_1,
  // Serial bus, data pin split into in, out and enable
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n,
  // Port pins
  input wire [15:0] port_in,
  output wire [15:0] port_out,
  output wire [15:0] port_oe_n,
  // Interrupt, open drain
  output wire int_out,
  output wire int_oe_n
);
`include "io_expander_defines.vh"
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_IGNORE = 3'h5;
////////////////////////////////////////////////////////////////////////////
  // Synchronisers; only the second stage is ever read
  reg [1:0] scl_s, sda_s, rst_s, a0_s, a1_s;
  reg [15:0] pin_s1, pin_s2;
  reg scl_d, sda_d;
  always @(posedge clk)
  begin
    scl_s <= {scl_s[0], scl};
    sda_s <= {sda_s[0], sda_in};
    rst_s <= {rst_s[0], ext_reset_n};
    a0_s <= {a0_s[0], addr_select_0};
    a1_s <= {a1_s[0], addr_select_1};
    pin_s1 <= port_in;
    pin_s2 <= pin_s1;
    scl_d <= scl_s[1];
    sda_d <= sda_s[1];
  end
  // Either source of reset yields identical initialisation
  wire rst_n = resetn & rst_s[1];
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire stop_c = scl_s[1] & scl_d & ~sda_d & sda_s[1];
////////////////////////////////////////////////////////////////////////////
  // Register bank
  reg wr_en;
  reg [2:0] ptr;
  reg [7:0] shift;
  wire [7:0] rd_data;
  wire [63:0] regs;
  reg_bank #(.WIDTH(8), .DEPTH(8), .AW(3)) bank (
    .clk(clk),
    .resetn(rst_n),
    .wr_en(wr_en),
    .wr_addr(ptr),
    .wr_data(shift),
    .rd_addr(ptr),
    .rd_data(rd_data),
    .all_data(regs)
  );
  wire [15:0] out_reg = regs[8*`CMD_OUTPUT_0 +: 16];
  wire [15:0] pol_reg = regs[8*`CMD_POLARITY_0 +: 16];
  wire [15:0] cfg_reg = regs[8*`CMD_CONFIG_0 +: 16];
  // Outputs follow stored values; config 1 means input (released)
  assign port_out = out_reg;
  assign port_oe_n = cfg_reg;
////////////////////////////////////////////////////////////////////////////
  // Input snapshot, refreshed when the master reads an input byte
  reg [15:0] in_snap;
  reg snap_lo, snap_hi;
  wire [15:0] pin_pol = pin_s2 ^ pol_reg;
  always @(posedge clk)
  begin
    // Taking the live pins in reset keeps a high pin from raising the
    // interrupt on the first cycle after release
    if (!rst_n)
      in_snap <= pin_s2;
    else
    begin
      if (snap_lo)
        in_snap[7:0] <= pin_s2[7:0];
      if (snap_hi)
        in_snap[15:8] <= pin_s2[15:8];
    end
  end
  // Clears itself once pins match the stored snapshot again
  reg int_act;
  always @(posedge clk)
  begin
    if (!rst_n)
      int_act <= 1'b0;
    else
      int_act <= |((pin_s2 ^ in_snap) & cfg_reg);
  end
  assign int_out = 1'b0;
  assign int_oe_n = ~int_act;
////////////////////////////////////////////////////////////////////////////
  // Target address: fixed upper bits plus straps sampled after release
  reg [6:0] my_addr;
  always @(posedge clk)
  begin
    if (!rst_n)
      my_addr <= {`ADDR_FIXED_BITS, 2'b00};
    else
      my_addr <= {`ADDR_FIXED_BITS, a1_s[1], a0_s[1]};
  end
////////////////////////////////////////////////////////////////////////////
  // Target state machine; it only ever answers, never drives scl
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg rw;
  reg ack_phase;
  reg [7:0] tx;
  assign sda_out = 1'b0;
  always @*
  begin
    snap_lo = 1'b0;
    snap_hi = 1'b0;
    if (state == ST_READ && scl_fall && bitcnt == `BIT_ACK)
    begin
      snap_lo = (ptr == `CMD_INPUT_0);
      snap_hi = (ptr == `CMD_INPUT_1);
    end
  end
  function [7:0] read_byte;
    input [2:0] p;
    input [15:0] pins;
    input [7:0] stored;
    begin
      if (p == `CMD_INPUT_0)
        read_byte = pins[7:0];
      else if (p == `CMD_INPUT_1)
        read_byte = pins[15:8];
      else
        read_byte = stored;
    end
  endfunction
  // The pair's other byte comes from the flat view, since the registered
  // read port still shows the old pointer when the next byte is due
  wire [2:0] ptr_pair = {ptr[2:1], ~ptr[0]};
  wire [7:0] first_byte = read_byte(ptr, pin_pol, rd_data);
  wire [7:0] next_byte = read_byte(ptr_pair, pin_pol,
                                   regs[{ptr_pair, 3'h0} +: 8]);
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      bitcnt <= `BIT_FIRST;
      shift <= 8'h00;
      rw <= 1'b0;
      ptr <= 3'h0;
      wr_en <= 1'b0;
      sda_oe_n <= 1'b1;
      ack_phase <= 1'b0;
      tx <= 8'h00;
    end
    else
    begin
      wr_en <= 1'b0;
      if (start_c)
      begin
        state <= ST_ADDR;
        bitcnt <= `BIT_FIRST;
        sda_oe_n <= 1'b1;
      end
      else if (stop_c)
      begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (scl_rise && state != ST_IDLE && state != ST_READ &&
               bitcnt <= `BIT_LAST)
      begin
        shift <= {shift[6:0], sda_s[1]};
        bitcnt <= bitcnt + 4'h1;
      end
      else if (scl_rise && state == ST_READ && bitcnt == `BIT_ACK)
        ack_phase <= ~sda_s[1];
      else if (scl_fall)
      begin
        case (state)
          ST_ADDR:
          begin
            if (bitcnt == `BIT_ACK && sda_oe_n)
            begin
              if (shift[7:1] == my_addr)
              begin
                sda_oe_n <= 1'b0;
                rw <= shift[0];
              end
              else
                state <= ST_IGNORE;
            end
            else if (bitcnt == `BIT_ACK)
            begin
              sda_oe_n <= 1'b1;
              bitcnt <= `BIT_FIRST;
              state <= rw ? ST_READ : ST_CMD;
              if (rw)
              begin
                tx <= first_byte;
                sda_oe_n <= first_byte[7];
              end
            end
          end
          ST_CMD, ST_WRITE:
          begin
            if (bitcnt == `BIT_ACK && sda_oe_n)
            begin
              sda_oe_n <= 1'b0;
              if (state == ST_CMD)
                ptr <= shift[2:0];
              else
                wr_en <= (ptr != `CMD_INPUT_0) && (ptr != `CMD_INPUT_1);
            end
            else if (bitcnt == `BIT_ACK)
            begin
              sda_oe_n <= 1'b1;
              bitcnt <= `BIT_FIRST;
              if (state == ST_WRITE)
                ptr <= {ptr[2:1], ~ptr[0]};
              state <= ST_WRITE;
            end
          end
          ST_READ:
          begin
            if (bitcnt < `BIT_LAST)
            begin
              sda_oe_n <= tx[6];
              tx <= {tx[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
            else if (bitcnt == `BIT_LAST)
            begin
              sda_oe_n <= 1'b1;
              bitcnt <= `BIT_ACK;
            end
            else if (ack_phase)
            begin
              ptr <= ptr_pair;
              bitcnt <= `BIT_FIRST;
              tx <= next_byte;
              sda_oe_n <= next_byte[7];
            end
            else
              state <= ST_IGNORE;
          end
          default:
          begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// File: dv/expander_props.sv
// Checker for the expander control block ports
module expander_props (
  // Clock and resets
  input wire clk,
  input wire resetn,
  input wire ext_reset_n,
  // Bus and pins
  input wire scl,
  input wire sda_out,
  input wire sda_oe_n,
  input wire [15:0] port_in,
  input wire [15:0] port_out,
  input wire [15:0] port_oe_n,
  input wire int_out,
  input wire int_oe_n
);
  logic [7:0] quiet;
  logic [7:0] sq;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Saturating ages of the last pin and bus clock edge
  always @(posedge clk)
  begin
    if (!resetn)
      quiet <= 8'hff;
    else if (port_in != $past(port_in))
      quiet <= 8'h00;
    else if (quiet != 8'hff)
      quiet <= quiet + 8'h01;
    if (!resetn)
      sq <= 8'hff;
    else if (scl != $past(scl))
      sq <= 8'h00;
    else if (sq != 8'hff)
      sq <= sq + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_POR_DEFAULTS: assert property ($rose(resetn) |->
    port_oe_n == 16'hffff && port_out == 16'hffff) else $error("por default");
  AST_POR_RELEASE: assert property ($rose(resetn) |->
    int_oe_n && sda_oe_n) else $error("por release");
  AST_PIN_RESET: assert property (!ext_reset_n [*5] |->
    port_oe_n == 16'hffff && port_out == 16'hffff) else $error("pin reset");
  AST_PIN_RESET_INT: assert property (!ext_reset_n [*5] |-> int_oe_n)
    else $error("int during pin reset");
  AST_OPEN_DRAIN: assert property (int_out == 1'b0 && sda_out == 1'b0)
    else $error("open drain level");
  AST_TARGET_ONLY: assert property ($fell(sda_oe_n) |-> !scl)
    else $error("data pulled with clock high");
  AST_INT_CAUSE: assert property ($fell(int_oe_n) |-> quiet < 8'h0c)
    else $error("int without pin change");
  AST_INT_CLEAR: assert property ($rose(int_oe_n) |-> quiet < 8'h0c ||
    sq < 8'h28 || !$past(ext_reset_n, 3)) else $error("int cleared");
  AST_OUT_LATCHED: assert property ($changed(port_out) |->
    sq < 8'h28 || !$past(ext_reset_n, 3)) else $error("output moved");
  cover property ($fell(int_oe_n));
  cover property ($rose(int_oe_n));
  cover property ($fell(sda_oe_n));
endmodule
bind io_expander_ctrl expander_props u_props (.clk(clk), .resetn(resetn),
  .ext_reset_n(ext_reset_n), .scl(scl), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .port_in(port_in), .port_out(port_out),
  .port_oe_n(port_oe_n), .int_out(int_out), .int_oe_n(int_oe_n));

// File: dv/bus_master_model.sv
// Bus master model: serial bus, reset pin and interrupt input
module bus_master_model (
  // Clock
  input wire clk,
  // Board lines
  input wire sda_wire,
  input wire int_line, // Master learns of input changes here
  output logic scl,
  output logic sda_drv,
  output logic ext_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ext_reset_n = 1'b1;
  end
  // Quarter of the 160 ns bus clock
  task automatic q;
    repeat (8) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    q();
    scl <= 1'b1;
    q();
    q();
    r = sda_wire;
    scl <= 1'b0;
    q();
  endtask
  task automatic start;
    sda_drv <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop;
    sda_drv <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b1;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  // Reset may be pulled at any moment, even mid-frame
  task automatic pin_reset;
    ext_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    ext_reset_n <= 1'b1;
  endtask
endmodule

// File: dv/tb_top.sv
// Testbench for the expander control block
`include "io_expander_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] straps = 2'h2;
  logic [15:0] port_in = 16'h0000;
  wire scl, sda_drv, ext_reset_n, sda_out, sda_oe_n, int_out, int_oe_n;
  wire [15:0] port_out, port_oe_n;
  wire sda_wire = sda_drv & (sda_oe_n | sda_out);
  wire int_line = int_oe_n | int_out;
  int failures = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  io_expander_ctrl DUT (.clk(clk), .resetn(resetn),
    .ext_reset_n(ext_reset_n), .addr_select_0(straps[0]),
    .addr_select_1(straps[1]), .scl(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .port_in(port_in),
    .port_out(port_out), .port_oe_n(port_oe_n), .int_out(int_out),
    .int_oe_n(int_oe_n));
  bus_master_model M (.clk(clk), .sda_wire(sda_wire), .int_line(int_line),
    .scl(scl), .sda_drv(sda_drv), .ext_reset_n(ext_reset_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [7:0] addr(input logic [1:0] s, input logic rd);
    return {`ADDR_FIXED_BITS, s, rd};
  endfunction
  // Bounded wait; the check that follows judges the level
  task automatic wait_int(input logic e);
    for (int i = 0; i < 20 && int_line !== e; i++) @(posedge clk);
  endtask
  task automatic write2(input logic [7:0] cmd, d0, d1);
    logic [3:0] a;
    M.start();
    M.wbyte(addr(straps, 1'b0), a[0]);
    M.wbyte(cmd, a[1]);
    M.wbyte(d0, a[2]);
    M.wbyte(d1, a[3]);
    M.stop();
    check("write acks", 16'h000f, {12'h000, a});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("dir after reset", 16'hffff, port_oe_n);
    check("out after reset", 16'hffff, port_out);
    check("int after reset", 16'h0001, {15'h0, int_line});
  endtask
  task automatic t_address;
    logic a;
    for (int s = 0; s < 4; s++)
    begin
      straps <= s[1:0];
      repeat (4) @(posedge clk);
      M.start();
      M.wbyte(addr(2'h2, 1'b0), a);
      M.stop();
      check("strap ack", {15'h0, s == 2}, {15'h0, a});
    end
    straps <= 2'h2;
  endtask
  task automatic t_outputs;
    write2(8'h02, 8'ha5, 8'h3c);
    write2(8'h06, 8'h00, 8'hff);
    check("latched out", 16'h3ca5, port_out);
    check("pin dir", 16'hff00, port_oe_n);
  endtask
  task automatic t_irq;
    logic [7:0] d;
    logic a;
    port_in <= 16'h0001;
    wait_int(1'b0);
    check("int on output pin", 16'h0001, {15'h0, int_line});
    port_in <= 16'h0101;
    wait_int(1'b0);
    check("int on input pin", 16'h0000, {15'h0, int_line});
    port_in <= 16'h0001;
    wait_int(1'b1);
    check("int on return", 16'h0001, {15'h0, int_line});
    port_in <= 16'h0201;
    wait_int(1'b0);
    check("int again", 16'h0000, {15'h0, int_line});
    M.start();
    M.wbyte(addr(straps, 1'b0), a);
    M.wbyte(8'h01, a);
    M.start();
    M.wbyte(addr(straps, 1'b1), a);
    M.rbyte(1'b0, d);
    check("read high byte", 16'h0002, {8'h00, d});
    M.rbyte(1'b1, d);
    check("read low byte", 16'h0001, {8'h00, d});
    M.stop();
    wait_int(1'b1);
    check("int after read", 16'h0001, {15'h0, int_line});
  endtask
  task automatic t_pin_reset;
    logic a;
    port_in <= 16'h0000;
    M.start();
    M.wbyte(addr(straps, 1'b0), a);
    M.pin_reset();
    repeat (4) @(posedge clk);
    check("dir after pin", 16'hffff, port_oe_n);
    check("out after pin", 16'hffff, port_out);
    check("int after pin", 16'h0001, {15'h0, int_line});
    write2(8'h02, 8'h0f, 8'hf0);
    check("out rewritten", 16'hf00f, port_out);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_address();
    t_outputs();
    t_irq();
    t_pin_reset();
    results();
  end
  initial
  begin
    #400us;
    failures++;
    results();
  end
endmodule
